// ==== bench/host_model.sv ====
// Host model driving the three-wire load pins.
// Assumes CLK at 50 MHz; pins change on its falling edge, link clock 160 ns.
module host_model (
  input wire logic CLK,
  output logic sclk,
  output logic sdi,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    strobe = 1'b1;
    sdi = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic start();
    strobe <= 1'b0;
    wait_n(4);
  endtask
  // One link clock period, data set before the rise
  task automatic shift(input logic b);
    sdi <= b;
    sclk <= 1'b0;
    wait_n(4);
    sclk <= 1'b1;
    wait_n(4);
  endtask
  task automatic latch();
    strobe <= 1'b1;
    sdi <= ~sdi;
    wait_n(6);
  endtask
endmodule

// ==== bench/serial_octal_dac_loader_tb.sv ====
// Self-checking bench for the serial converter load path.
// Assumes the host model drives all link pins.
module serial_octal_dac_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst;
  logic sclk;
  logic sdi;
  logic strobe;
  logic serial_out;
  logic update_pulse;
  logic [63:0] channel_code;
  logic [3:0] frame_bits;
  logic [63:0] exp_code;
  logic [11:0] last_bits;
  int n_fail;
  int n_checks;
  int n_pulse;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) if (update_pulse === 1'b1) n_pulse++;
  host_model u_host_model (.CLK(clk), .sclk(sclk), .sdi(sdi), .strobe(strobe));
  serial_octal_dac_loader u_serial_octal_dac_loader (.CLK(clk), .RST(rst), .SCLK(sclk),
    .SERIAL_IN_PIN(sdi), .LATCH_STROBE(strobe), .SERIAL_OUT(serial_out),
    .CHANNEL_CODE(channel_code), .UPDATE_PULSE(update_pulse), .FRAME_BITS(frame_bits));
  task automatic check(input logic [63:0] got, input logic [63:0] want);
    n_checks++;
    if (got !== want) begin
      n_fail++;
      $display("mismatch at %0t got %0h want %0h", $time, got, want);
    end
  endtask
  // Full frame; previous frame must leave on the cascade output
  task automatic frame(input logic [7:0] code, input logic [3:0] sel);
    int p;
    logic [11:0] w;
    p = n_pulse;
    for (int i = 0; i < 12; i++) w[i] = (i < 8) ? code[i] : sel[11 - i];
    u_host_model.start();
    for (int i = 0; i < 12; i++) begin
      u_host_model.shift(w[i]);
      check({63'h0, serial_out}, {63'h0, last_bits[i]});
    end
    check({60'h0, frame_bits}, 64'hC);
    u_host_model.latch();
    last_bits = w;
    if (sel >= 4'h1 && sel <= 4'h8) exp_code[(sel - 1) * 8 +: 8] = code;
    check(64'(n_pulse - p), (sel >= 4'h1 && sel <= 4'h8) ? 64'h1 : 64'h0);
    check(channel_code, exp_code);
  endtask
  task automatic t_all_channels();
    for (int k = 1; k <= 8; k++) frame(8'(8'h1F * k), 4'(k));
  endtask
  task automatic t_bad_select();
    frame(8'hA5, 4'h0);
    frame(8'h5A, 4'h9);
    frame(8'h3C, 4'hF);
  endtask
  task automatic t_strobe_high();
    repeat (3) u_host_model.shift(1'b1);
    check({60'h0, frame_bits}, 64'h0);
    check(channel_code, exp_code);
    frame(8'hFF, 4'h1);
  endtask
  // Reset in mid-run clears codes, count and cascade output
  task automatic t_mid_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(channel_code, 64'h0);
    check({63'h0, serial_out}, 64'h0);
    check({60'h0, frame_bits}, 64'h0);
    check({63'h0, update_pulse}, 64'h0);
    rst = 1'b0;
    exp_code = 64'h0;
    last_bits = 12'h000;
    u_host_model.wait_n(4);
    frame(8'h42, 4'h5);
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    exp_code = 64'h0;
    last_bits = 12'h000;
    n_fail = 0;
    n_checks = 0;
    n_pulse = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    u_host_model.wait_n(4);
    check(channel_code, 64'h0);
    t_all_channels();
    t_bad_select();
    t_strobe_high();
    t_mid_reset();
    end_of_test();
  end
endmodule

// ==== hdl/pin_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes CLK is free running; first stage feeds only the second.
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] stable_q;
  logic [W-1:0] stable_d;

  always_comb begin
    meta_d = async_in;
    stable_d = meta_q;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= INIT;
      stable_q <= INIT;
    end else begin
      meta_q <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_out = stable_q;
endmodule

// ==== hdl/serial_octal_dac_loader.sv ====
// Serial load interface of an eight-channel 8-bit converter.
// Assumes host drives SCLK, SERIAL_IN_PIN and LATCH_STROBE, all asynchronous to CLK.
module serial_octal_dac_loader (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic SERIAL_IN_PIN,
  input wire logic LATCH_STROBE,
  output logic SERIAL_OUT,
  output logic [63:0] CHANNEL_CODE,
  output logic UPDATE_PULSE,
  output logic [3:0] FRAME_BITS
);
  logic [2:0] pins_raw;
  logic [2:0] pins_s;
  logic sclk_s;
  logic sdi_s;
  logic strobe_s;
  logic sclk_prev_q;
  logic sclk_prev_d;
  logic strobe_prev_q;
  logic strobe_prev_d;
  logic shift_en;
  logic latch_en;
  logic [11:0] sr_q;
  logic [11:0] sr_d;
  logic sdo_q;
  logic sdo_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic upd_q;
  logic upd_d;
  logic [7:0] word_code;
  logic [3:0] word_sel;
  logic sel_valid;
  logic [7:0] chan_q [dac_load_pkg::NUM_CHAN];
  logic [7:0] chan_d [dac_load_pkg::NUM_CHAN];

  assign pins_raw = {SCLK, SERIAL_IN_PIN, LATCH_STROBE};

  pin_sync #(
    .W(3),
    .INIT(3'h5)
  ) u_sync (
    .CLK(CLK),
    .RST(RST),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign strobe_s = pins_s[0];

  // Edge finding on synchronised pins
  always_comb begin
    sclk_prev_d = sclk_s;
    strobe_prev_d = strobe_s;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_prev_q <= 1'b1;
      strobe_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      strobe_prev_q <= strobe_prev_d;
    end
  end

  assign shift_en = sclk_s && !sclk_prev_q && !strobe_s;
  assign latch_en = strobe_s && !strobe_prev_q;

  // Word fields
  always_comb begin
    for (int i = 0; i < dac_load_pkg::CODE_BITS; i++) begin
      word_code[i] = sr_q[dac_load_pkg::CODE_FIRST_POS - i];
    end
    word_sel = sr_q[dac_load_pkg::SEL_MSB_POS:0];
    sel_valid = (word_sel >= dac_load_pkg::SEL_FIRST) && (word_sel <= dac_load_pkg::SEL_LAST);
  end

  // Shift register, frame counter and serial output
  always_comb begin
    sr_d = sr_q;
    sdo_d = sdo_q;
    cnt_d = cnt_q;
    upd_d = 1'b0;
    if (shift_en) begin
      sr_d = {sr_q[10:0], sdi_s};
      sdo_d = sr_q[11];
      if (cnt_q != dac_load_pkg::CNT_FULL) begin
        cnt_d = cnt_q + 4'h1;
      end
    end
    if (strobe_s && strobe_prev_q) begin
      cnt_d = dac_load_pkg::CNT_RESET;
    end
    if (latch_en) begin
      upd_d = sel_valid;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sr_q <= dac_load_pkg::SHIFT_RESET;
      sdo_q <= 1'b0;
      cnt_q <= dac_load_pkg::CNT_RESET;
      upd_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      sdo_q <= sdo_d;
      cnt_q <= cnt_d;
      upd_q <= upd_d;
    end
  end

  // Channel code latches
  genvar ch;
  generate
    for (ch = 0; ch < dac_load_pkg::NUM_CHAN; ch++) begin : g_chan
      always_comb begin
        chan_d[ch] = chan_q[ch];
        if (latch_en && sel_valid && (word_sel == 4'(ch + 1))) begin
          chan_d[ch] = word_code;
        end
      end

      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          chan_q[ch] <= dac_load_pkg::CODE_RESET;
        end else begin
          chan_q[ch] <= chan_d[ch];
        end
      end

      assign CHANNEL_CODE[ch*8 +: 8] = chan_q[ch];
    end
  endgenerate

  assign SERIAL_OUT = sdo_q;
  assign UPDATE_PULSE = upd_q;
  assign FRAME_BITS = cnt_q;

  // Checks
  sequence s_clk_rise_low;
    sclk_s && !sclk_prev_q && !strobe_s;
  endsequence

  sequence s_strobe_rise;
    strobe_s && !strobe_prev_q;
  endsequence

  property p_shift_only_on_edge;
    @(posedge CLK) disable iff (RST)
      (sr_q != $past(sr_q)) |-> $past(sclk_s && !sclk_prev_q && !strobe_s);
  endproperty
  a_shift_only_on_edge: assert property (p_shift_only_on_edge)
    else $error("shift register moved without a sampling edge");

  property p_frame_count;
    @(posedge CLK) disable iff (RST)
      (s_clk_rise_low and (cnt_q < dac_load_pkg::CNT_FULL)) |=> (cnt_q == $past(cnt_q) + 4'h1);
  endproperty
  a_frame_count: assert property (p_frame_count)
    else $error("frame bit count did not advance");

  property p_twelve_bits_hold_word;
    @(posedge CLK) disable iff (RST)
      (s_clk_rise_low and (cnt_q == dac_load_pkg::CNT_FULL - 4'h1)) |=>
        (sr_q[0] == $past(sdi_s)) && (cnt_q == dac_load_pkg::CNT_FULL);
  endproperty
  a_twelve_bits_hold_word: assert property (p_twelve_bits_hold_word)
    else $error("twelfth bit not captured");

  property p_latch_updates;
    @(posedge CLK) disable iff (RST)
      (s_strobe_rise and (word_sel == 4'h3)) |=> (chan_q[2] == $past(word_code)) && UPDATE_PULSE;
  endproperty
  a_latch_updates: assert property (p_latch_updates)
    else $error("addressed channel not updated on strobe rise");

  property p_serial_out;
    @(posedge CLK) disable iff (RST)
      s_clk_rise_low |=> (SERIAL_OUT == $past(sr_q[11]));
  endproperty
  a_serial_out: assert property (p_serial_out)
    else $error("serial output does not carry the departing bit");

  property p_code_stable;
    @(posedge CLK) disable iff (RST)
      !latch_en |=> (CHANNEL_CODE == $past(CHANNEL_CODE));
  endproperty
  a_code_stable: assert property (p_code_stable)
    else $error("channel code changed without a latch");

  property p_bad_select;
    @(posedge CLK) disable iff (RST)
      (s_strobe_rise and !sel_valid) |=> (CHANNEL_CODE == $past(CHANNEL_CODE)) && !UPDATE_PULSE;
  endproperty
  a_bad_select: assert property (p_bad_select)
    else $error("invalid select updated a channel");
endmodule

// ==== pkg/dac_load_pkg.sv ====
// Constants for the serial eight-channel converter load path.
// Assumes a single system clock at 50 MHz sampling all serial pins.
package dac_load_pkg;
  localparam int WORD_BITS = 12;
  localparam int CODE_BITS = 8;
  localparam int SEL_BITS = 4;
  localparam int NUM_CHAN = 8;
  localparam int SYNC_STAGES = 2;
  // Word layout: first bit in lands at the top of the shift register
  localparam int CODE_FIRST_POS = 11;
  localparam int SEL_MSB_POS = 3;
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST = 4'h8;
  localparam logic [11:0] SHIFT_RESET = 12'h000;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_FULL = 4'hC;
endpackage
